/* rtl/flash_status_poller.v */
// Host-side controller that polls the status word of an asynchronous flash.
// Assumes an Avalon-MM master on clk and a flash wired to the f_* pins.
// Contract
// - Toggle advances only across strobe deassertion; host cycles strobes.
// - Host begins with two back-to-back reads and compares toggle bits.
// - On persistent toggle, check timeout, retest, fail leads to reset.
// - Resuming after other work restarts polling from the double read.
// - Status reads are never interleaved with reads of other sectors.
// - After timeout failure host writes the reset command.
// - On buffer abort host issues the write-buffer abort reset sequence.
// - Buffer programming is polled at the last loaded address.
//
// Decided for this implementation: the Avalon-MM register port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "flash_poll_defs.vh"
module flash_status_poller #(
  parameter ACCESS_CYC = `T_ACCESS_CYC,
  parameter HIGH_CYC = `T_HIGH_CYC
) (
  input wire clk,
  input wire resetn,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg [23:0] flash_addr,
  output reg flash_ce_n,
  output reg flash_oe_n,
  output reg flash_we_n,
  output reg [15:0] flash_dq_out,
  output reg flash_dq_oe,
  input wire [15:0] flash_dq_in,
  input wire ready_busy_n,
  output reg flash_reset_n
);
  // ****************************************
  // States
  // ****************************************
  localparam S_IDLE = 8'b0000_0001;
  localparam S_READ1 = 8'b0000_0010;
  localparam S_READ2 = 8'b0000_0100;
  localparam S_RETEST = 8'b0000_1000;
  localparam S_CMD = 8'b0001_0000;
  localparam S_FINAL = 8'b0010_0000;
  localparam S_WAIT = 8'b0100_0000;
  localparam S_DONE = 8'b1000_0000;

  // ****************************************
  // Input synchronisers
  // ****************************************
  reg [15:0] dq_meta, dq_sync;
  reg rb_meta, rb_sync;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dq_meta <= 16'h0000;
      dq_sync <= 16'h0000;
      rb_meta <= 1'b1;
      rb_sync <= 1'b1;
    end else begin
      dq_meta <= flash_dq_in;
      dq_sync <= dq_meta;
      rb_meta <= ready_busy_n;
      rb_sync <= rb_meta;
    end
  end

  // ****************************************
  // Bus cycle engine
  // ****************************************
  reg cyc_req, cyc_wr;
  reg [23:0] cyc_addr;
  reg [15:0] cyc_wdata;
  wire cyc_ack;
  wire [15:0] cyc_rdata;
  wire [23:0] c_addr;
  wire c_ce_n, c_oe_n, c_we_n, c_dq_oe;
  wire [15:0] c_dq_out;
  flash_bus_cycle #(.ACCESS_CYC(ACCESS_CYC), .HIGH_CYC(HIGH_CYC)) u_cycle (
    .clk(clk),
    .resetn(resetn),
    .req(cyc_req),
    .wr(cyc_wr),
    .addr(cyc_addr),
    .wdata(cyc_wdata),
    .ack(cyc_ack),
    .rdata(cyc_rdata),
    .f_addr(c_addr),
    .f_ce_n(c_ce_n),
    .f_oe_n(c_oe_n),
    .f_we_n(c_we_n),
    .f_dq_out(c_dq_out),
    .f_dq_oe(c_dq_oe),
    .f_dq_in(dq_sync)
  );
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flash_addr <= 24'h00_0000;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_dq_out <= 16'h0000;
      flash_dq_oe <= 1'b0;
      flash_reset_n <= 1'b1;
    end else begin
      flash_addr <= c_addr;
      flash_ce_n <= c_ce_n;
      flash_oe_n <= c_oe_n;
      flash_we_n <= c_we_n;
      flash_dq_out <= c_dq_out;
      flash_dq_oe <= c_dq_oe;
      flash_reset_n <= 1'b1;
    end
  end

  // ****************************************
  // Registers and polling sequencer
  // ****************************************
  reg [7:0] state;
  reg [23:0] poll_addr;
  reg erase_mode, busy, done, fail, abort_seen, erase_started, kill;
  reg [15:0] first_word, last_word;
  reg [2:0] cmd_idx, cmd_len;
  reg cmd_abort;
  wire toggled = first_word[`BIT_FIRST_TOGGLE] != cyc_rdata[`BIT_FIRST_TOGGLE];
  wire tog2 = first_word[`BIT_SECOND_TOGGLE] != cyc_rdata[`BIT_SECOND_TOGGLE];

  // Reset sequences: plain reset, or unlock-unlock-reset for buffer abort
  function [39:0] cmd_word;
    input abort_seq;
    input [2:0] idx;
    begin
      if (!abort_seq || idx == 3'd2)
        cmd_word = {`ADDR_UNLOCK1, `CMD_RESET};
      else if (idx == 3'd0)
        cmd_word = {`ADDR_UNLOCK1, `CMD_UNLOCK1};
      else
        cmd_word = {`ADDR_UNLOCK2, `CMD_UNLOCK2};
    end
  endfunction

  wire bus_sel = avs_read | avs_write;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= S_IDLE;
      poll_addr <= 24'h00_0000;
      erase_mode <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      fail <= 1'b0;
      abort_seen <= 1'b0;
      erase_started <= 1'b0;
      first_word <= 16'h0000;
      last_word <= 16'h0000;
      cmd_idx <= 3'd0;
      cmd_len <= 3'd0;
      cmd_abort <= 1'b0;
      kill <= 1'b0;
      cyc_req <= 1'b0;
      cyc_wr <= 1'b0;
      cyc_addr <= 24'h00_0000;
      cyc_wdata <= 16'h0000;
      avs_readdata <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
    end else begin
      cyc_req <= 1'b0;
      avs_waitrequest <= 1'b1;
      // Slave answers one cycle after the request is seen
      if (bus_sel && avs_waitrequest && !(avs_read && avs_write)) begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= 32'h0000_0000;
        if (avs_write && avs_address == `REG_ADDR)
          poll_addr <= avs_writedata[23:0];
        if (avs_write && avs_address == `REG_CTRL && state == S_IDLE) begin
          erase_mode <= avs_writedata[`CTRL_MODE];
          if (avs_writedata[`CTRL_START]) begin
            // Always from the double read, never a mid-poll resume
            state <= S_READ1;
            busy <= 1'b1;
            done <= 1'b0;
            fail <= 1'b0;
            abort_seen <= 1'b0;
            erase_started <= 1'b0;
            cyc_req <= 1'b1;
            cyc_wr <= 1'b0;
            cyc_addr <= poll_addr;
          end else if (avs_writedata[`CTRL_RESET_CMD] | avs_writedata[`CTRL_ABORT_CMD]) begin
            state <= S_CMD;
            busy <= 1'b1;
            cmd_abort <= avs_writedata[`CTRL_ABORT_CMD];
            cmd_len <= avs_writedata[`CTRL_ABORT_CMD] ? 3'd3 : 3'd1;
            cmd_idx <= 3'd0;
            kill <= 1'b0;
          end
        end
        if (avs_read && avs_address == `REG_STATUS)
          avs_readdata <= {26'h000_0000, rb_sync, erase_started, abort_seen, fail, done, busy};
        else if (avs_read && avs_address == `REG_DATA)
          avs_readdata <= {16'h0000, last_word};
        else if (avs_read && avs_address == `REG_ADDR)
          avs_readdata <= {8'h00, poll_addr};
        else if (avs_read && avs_address == `REG_CTRL)
          avs_readdata <= {31'h0000_0000, erase_mode};
      end
      case (state)
        S_IDLE: ;
        // Only poll_addr is read, so no other sector interleaves
        S_READ1: if (cyc_ack) begin
          first_word <= cyc_rdata;
          state <= S_READ2;
          cyc_req <= 1'b1;
          cyc_addr <= poll_addr;
        end
        S_READ2: if (cyc_ack) begin
          last_word <= cyc_rdata;
          if (erase_mode && cyc_rdata[`BIT_ERASE_STARTED])
            erase_started <= 1'b1;
          if (!toggled && !(erase_mode && tog2)) begin
            state <= S_FINAL;
            cyc_req <= 1'b1;
            cyc_addr <= poll_addr;
          end else if (cyc_rdata[`BIT_BUFFER_ABORT] && first_word[`BIT_BUFFER_ABORT] &&
              !erase_mode) begin
            // Both reads must show abort: array data after completion may have bit 1 set
            abort_seen <= 1'b1;
            cmd_abort <= 1'b1;
            cmd_len <= 3'd3;
            cmd_idx <= 3'd0;
            kill <= 1'b1;
            state <= S_CMD;
          end else if (cyc_rdata[`BIT_TIMEOUT_FAIL]) begin
            first_word <= cyc_rdata;
            state <= S_RETEST;
            cyc_req <= 1'b1;
            cyc_addr <= poll_addr;
          end else begin
            first_word <= cyc_rdata;
            cyc_req <= 1'b1;
            cyc_addr <= poll_addr;
          end
        end
        S_RETEST: if (cyc_ack) begin
          last_word <= cyc_rdata;
          if (!toggled) begin
            state <= S_FINAL;
            cyc_req <= 1'b1;
            cyc_addr <= poll_addr;
          end else begin
            fail <= 1'b1;
            cmd_abort <= 1'b0;
            cmd_len <= 3'd1;
            cmd_idx <= 3'd0;
            kill <= 1'b1;
            state <= S_CMD;
          end
        end
        S_CMD: begin
          cyc_req <= 1'b1;
          cyc_wr <= 1'b1;
          {cyc_addr, cyc_wdata} <= cmd_word(cmd_abort, cmd_idx);
          state <= S_WAIT;
        end
        S_WAIT: if (cyc_ack) begin
          cyc_wr <= 1'b0;
          if (cmd_idx + 3'd1 >= cmd_len) begin
            state <= S_DONE;
          end else begin
            cmd_idx <= cmd_idx + 3'd1;
            state <= S_CMD;
          end
        end
        // Array data on the read after the toggle stopped
        S_FINAL: if (cyc_ack) begin
          last_word <= cyc_rdata;
          state <= S_DONE;
        end
        S_DONE: begin
          busy <= 1'b0;
          done <= 1'b1;
          kill <= 1'b0;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule // flash_status_poller
`default_nettype wire

/* rtl/flash_poll_defs.vh */
// Constants for the flash status polling controller.
// Assumes inclusion by bare name from rtl/ files; definitions only.
`ifndef FLASH_POLL_DEFS_VH
`define FLASH_POLL_DEFS_VH
// ****************************************
// Register offsets (byte addresses, word aligned)
// ****************************************
`define REG_CTRL 4'h0
`define REG_ADDR 4'h4
`define REG_STATUS 4'h8
`define REG_DATA 4'hc
// ****************************************
// Control fields
// ****************************************
`define CTRL_START 0
`define CTRL_MODE 1
`define CTRL_RESET_CMD 2
`define CTRL_ABORT_CMD 3
// ****************************************
// Status fields
// ****************************************
`define ST_BUSY 0
`define ST_DONE 1
`define ST_FAIL 2
`define ST_ABORT 3
`define ST_ERASE_STARTED 4
`define ST_PIN_READY 5
// ****************************************
// Data bus bit positions of the status word
// ****************************************
`define BIT_DATA_POLLING 7
`define BIT_FIRST_TOGGLE 6
`define BIT_TIMEOUT_FAIL 5
`define BIT_ERASE_STARTED 3
`define BIT_SECOND_TOGGLE 2
`define BIT_BUFFER_ABORT 1
// ****************************************
// Timing (ns) and reset values
// ****************************************
`define CLK_PERIOD_NS 5
`define T_ACCESS_NS 90
`define T_ACCESS_CYC ((`T_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_HIGH_NS 30
`define T_HIGH_CYC ((`T_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CMD_RESET 16'h00f0
`define CMD_UNLOCK1 16'h00aa
`define CMD_UNLOCK2 16'h0055
`define ADDR_UNLOCK1 24'h00_0555
`define ADDR_UNLOCK2 24'h00_02aa
`endif

/* rtl/flash_bus_cycle.v */
// One asynchronous flash bus cycle (read or write) driven from the system clock.
// Assumes data_in is already synchronised by the caller; one request at a time.
`timescale 1ns/100ps
`default_nettype none
`include "flash_poll_defs.vh"
module flash_bus_cycle #(
  parameter ACCESS_CYC = `T_ACCESS_CYC,
  parameter HIGH_CYC = `T_HIGH_CYC
) (
  input wire clk,
  input wire resetn,
  input wire req,
  input wire wr,
  input wire [23:0] addr,
  input wire [15:0] wdata,
  output reg ack,
  output reg [15:0] rdata,
  output reg [23:0] f_addr,
  output reg f_ce_n,
  output reg f_oe_n,
  output reg f_we_n,
  output reg [15:0] f_dq_out,
  output reg f_dq_oe,
  input wire [15:0] f_dq_in
);
  localparam S_IDLE = 3'b001;
  localparam S_ACT = 3'b010;
  localparam S_HIGH = 3'b100;
  reg [2:0] state;
  reg [7:0] cnt;
  reg is_wr;
  // Pin register plus two-stage sync: a pin sample arrives here two edges late
  reg [1:0] cap_pipe;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= S_IDLE;
      cnt <= 8'h00;
      is_wr <= 1'b0;
      cap_pipe <= 2'b00;
      ack <= 1'b0;
      rdata <= 16'h0000;
      f_addr <= 24'h00_0000;
      f_ce_n <= 1'b1;
      f_oe_n <= 1'b1;
      f_we_n <= 1'b1;
      f_dq_out <= 16'h0000;
      f_dq_oe <= 1'b0;
    end else begin
      ack <= 1'b0;
      cap_pipe <= {cap_pipe[0], 1'b0};
      if (cap_pipe[1]) begin
        rdata <= f_dq_in;
      end
      case (state)
        S_IDLE: begin
          if (req) begin
            is_wr <= wr;
            f_addr <= addr;
            f_dq_out <= wdata;
            f_dq_oe <= wr;
            f_ce_n <= 1'b0;
            f_oe_n <= wr;
            f_we_n <= ~wr;
            cnt <= ACCESS_CYC[7:0];
            state <= S_ACT;
          end
        end
        S_ACT: begin
          if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
          end else begin
            // Sampling here would see the pins from before the strobes fell
            cap_pipe <= {cap_pipe[0], ~is_wr};
            // Both strobes rise so every cycle is a distinct read (toggle advances)
            f_ce_n <= 1'b1;
            f_oe_n <= 1'b1;
            f_we_n <= 1'b1;
            cnt <= HIGH_CYC[7:0];
            state <= S_HIGH;
          end
        end
        S_HIGH: begin
          f_dq_oe <= 1'b0;
          if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
          end else if (cap_pipe == 2'b00) begin
            ack <= 1'b1;
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule // flash_bus_cycle
`default_nettype wire

/* tb/flash_status_poller_sva.sv */
// Port checks for the status poller.
// Assumes ACCESS_CYC and HIGH_CYC of 2, as the bench sets them.
`timescale 1ns/100ps
`default_nettype none
module flash_poller_sva #(
  parameter ACCESS_CYC = 2,
  parameter HIGH_CYC = 2
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [23:0] flash_addr,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic flash_dq_oe,
  input wire logic flash_reset_n
);
  // ****
  // Checks
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire req = avs_read ^ avs_write;
  sequence rd_low;
    !flash_oe_n [*3];
  endsequence
  sequence rd_high;
    flash_oe_n [*3];
  endsequence
  ans_next_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered next cycle");
  ans_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer held past one cycle");
  no_req_a: assert property (!req |=> avs_waitrequest)
    else $error("answer without request");
  low_len_a: assert property ($fell(flash_oe_n) |-> rd_low ##1 flash_oe_n)
    else $error("read strobe low phase wrong");
  high_len_a: assert property ($rose(flash_oe_n) |-> rd_high)
    else $error("strobe high gap too short");
  ce_with_oe_a: assert property (!flash_oe_n |-> !flash_ce_n)
    else $error("read without chip enable");
  no_fight_a: assert property (!flash_oe_n |-> !flash_dq_oe && flash_we_n)
    else $error("host drives bus during read");
  addr_hold_a: assert property (!flash_oe_n && !$past(flash_oe_n) |-> $stable(flash_addr))
    else $error("address moved within read");
  pin_high_a: assert property (flash_reset_n)
    else $error("reset pin used");
endmodule // flash_poller_sva
bind flash_status_poller flash_poller_sva #(.ACCESS_CYC(ACCESS_CYC), .HIGH_CYC(HIGH_CYC))
  flash_poller_sva_inst (.clk, .resetn, .avs_read, .avs_write, .avs_waitrequest,
  .flash_addr, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_dq_oe, .flash_reset_n);
`default_nettype wire

/* tb/flash_dev_model.sv */
// Behavioural flash status logic: modes 1 program, 2 erase, 3 timeout, 4 abort,
// 5 erase suspended (status without toggle on the first toggle bit, not busy).
// Assumes the bench pulses go with mode and a count of busy reads.
`timescale 1ns/100ps
`default_nettype none
module flash_dev_model #(
  parameter [15:0] ARRAY = 16'h3c5a,
  parameter [7:0] ERASE_SECT = 8'h12
) (
  input wire logic [23:0] addr,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [15:0] dq_out,
  input wire logic go,
  input wire logic [2:0] mode,
  input wire logic [7:0] nreads,
  output wire logic [15:0] dq_in,
  output wire logic ready_busy_n
);
  // ****
  // Status word
  // ****
  reg [2:0] op = 3'h0;
  reg [7:0] left = 8'h00;
  reg tog = 1'b0;
  reg tog2 = 1'b0;
  reg [15:0] held = 16'h0000;
  reg [23:0] seq = 24'h00_0000;
  integer resets = 0;
  wire stat = op != 3'h0;
  // Erase suspend still answers with status but is not busy
  wire busy = stat && op != 3'h5;
  wire [15:0] word = !stat ? ARRAY : {8'h00, op == 3'h2 ? 1'b0 : ~ARRAY[7], tog,
    // Timeout only in mode 3: masked bits and skipped sectors raise no error
    op == 3'h3, 1'b0, op == 3'h2, tog2, op == 3'h4, 1'b0};
  // Released bus shows the inverse so a late sample cannot pass
  assign dq_in = (!ce_n && !oe_n) ? word : ~held;
  assign ready_busy_n = !busy;
  always @(posedge go) begin
    op = mode;
    left = nreads;
    tog = 1'b0;
    tog2 = 1'b0;
  end
  always @(posedge oe_n) begin
    held = word;
    if (stat) begin
      if (op != 3'h5) tog = ~tog;
      if ((op == 3'h2 || op == 3'h5) && addr[23:16] == ERASE_SECT) tog2 = ~tog2;
      if (op < 3'h3 && left == 8'h00) op = 3'h0;
      else if (op < 3'h3) left = left - 8'h01;
    end
  end
  // Abort state ignores a lone reset command
  always @(posedge we_n) begin
    seq = {seq[15:0], dq_out[7:0]};
    if (seq[7:0] == 8'hf0 && (op != 3'h4 || seq == 24'haa_55f0)) begin
      op = 3'h0;
      resets = resets + 1;
    end
  end
endmodule // flash_dev_model
`default_nettype wire

/* tb/flash_status_poller_tb.sv */
// Bench for the status poller with the flash model on its pins.
// Assumes Avalon answers by waitrequest low; all ends in report_and_stop.
`timescale 1ns/100ps
`default_nettype none
`include "flash_poll_defs.vh"
module flash_status_poller_tb;
  // ****
  // Bench
  // ****
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  wire [23:0] f_addr;
  wire f_ce_n, f_oe_n, f_we_n, f_dq_oe, f_rst_n, rb_n;
  wire [15:0] f_dq_out, f_dq_in;
  logic go = 1'b0;
  logic [2:0] mode = 3'h0;
  logic [7:0] nreads = 8'h00;
  int bad_count = 0;
  int n_tests = 0;
  int cycles = 0;
  flash_status_poller #(.ACCESS_CYC(2), .HIGH_CYC(2)) flash_status_poller_inst (
    .clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .flash_addr(f_addr), .flash_ce_n(f_ce_n),
    .flash_oe_n(f_oe_n), .flash_we_n(f_we_n), .flash_dq_out(f_dq_out),
    .flash_dq_oe(f_dq_oe), .flash_dq_in(f_dq_in), .ready_busy_n(rb_n),
    .flash_reset_n(f_rst_n));
  flash_dev_model flash_dev_model_inst (.addr(f_addr), .ce_n(f_ce_n), .oe_n(f_oe_n),
    .we_n(f_we_n), .dq_out(f_dq_out), .go(go), .mode(mode), .nreads(nreads),
    .dq_in(f_dq_in), .ready_busy_n(rb_n));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Hang guard: each operation needs fewer than a hundred cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // Starts one operation and polls until the poller reports it over
  task automatic run_op(input logic [2:0] m, input logic [7:0] nr, input logic [31:0] ctrl,
    output logic [31:0] st, output int nres);
    int r0;
    r0 = flash_dev_model_inst.resets;
    mode <= m;
    nreads <= nr;
    go <= 1'b1;
    bus(1'b1, `REG_CTRL, ctrl, st);
    go <= 1'b0;
    bus(1'b0, `REG_STATUS, 32'h0000_0000, st);
    check(st & 32'h0000_0020, (m == 3'h5) ? 32'h0000_0020 : 32'h0000_0000);
    while (st[`ST_BUSY] !== 1'b0 || st[`ST_DONE] !== 1'b1)
      bus(1'b0, `REG_STATUS, 32'h0000_0000, st);
    nres = flash_dev_model_inst.resets - r0;
  endtask
  task automatic test_reset();
    logic [31:0] q;
    bus(1'b0, `REG_STATUS, 32'h0000_0000, q);
    check(q, 32'h0000_0020);
    bus(1'b0, 4'h1, 32'h0000_0000, q);
    bus(1'b1, `REG_ADDR, 32'h0012_0040, q);
    bus(1'b0, `REG_ADDR, 32'h0000_0000, q);
    check(q, 32'h0012_0040);
    $display("test reset done");
  endtask
  task automatic test_program();
    logic [31:0] q;
    int nres;
    for (int i = 0; i < 8; i += 7) begin
      run_op(3'h1, i[7:0], 32'h0000_0001, q, nres);
      check(q & 32'h0000_003e, 32'h0000_0022);
      check(32'(nres), 32'h0000_0000);
      bus(1'b0, `REG_DATA, 32'h0000_0000, q);
      check(q, 32'h0000_3c5a);
    end
    $display("test program done");
  endtask
  task automatic test_erase();
    logic [31:0] q;
    int nres;
    run_op(3'h2, 8'h05, 32'h0000_0003, q, nres);
    check(q & 32'h0000_003e, 32'h0000_0032);
    check(32'(nres), 32'h0000_0000);
    $display("test erase done");
  endtask
  task automatic test_timeout();
    logic [31:0] q;
    int nres;
    run_op(3'h3, 8'h01, 32'h0000_0001, q, nres);
    check(q & 32'h0000_003e, 32'h0000_0026);
    check(32'(nres), 32'h0000_0001);
    $display("test timeout done");
  endtask
  task automatic test_abort();
    logic [31:0] q;
    int nres;
    run_op(3'h4, 8'h01, 32'h0000_0001, q, nres);
    check(q & 32'h0000_003e, 32'h0000_002a);
    check(32'(nres), 32'h0000_0001);
    $display("test abort done");
  endtask
  task automatic test_suspend();
    logic [31:0] q;
    int nres;
    run_op(3'h5, 8'h00, 32'h0000_0001, q, nres);
    check(q & 32'h0000_003e, 32'h0000_0022);
    check(32'(nres), 32'h0000_0000);
    bus(1'b0, `REG_DATA, 32'h0000_0000, q);
    check(q, 32'h0000_0080);
    $display("test suspend done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    test_reset();
    test_program();
    test_erase();
    test_timeout();
    test_abort();
    test_suspend();
    report_and_stop();
  end
endmodule // flash_status_poller_tb
`default_nettype wire
